// file: src/fpec_pkg.sv
/*
 * Shared constants and types of the flash program/erase controller:
 * register offsets, field positions, key values, operation codes,
 * alignment masks and operation timing.
 * Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package fpec_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FPEC_OFF_CTRL = 8'h00;
    localparam logic [7:0] FPEC_OFF_KEY = 8'h04;
    localparam logic [7:0] FPEC_OFF_PAGE = 8'h08;
    localparam logic [7:0] FPEC_OFF_OFFSET = 8'h0C;
    localparam logic [7:0] FPEC_OFF_WLO = 8'h10;
    localparam logic [7:0] FPEC_OFF_WHI = 8'h14;
    localparam logic [7:0] FPEC_OFF_STAT = 8'h18;

    // ------------------------------------------------------------
    // control register fields and reset value
    // ------------------------------------------------------------
    localparam int FPEC_START_BIT = 15;
    localparam int FPEC_EN_BIT = 14;
    localparam int FPEC_ERR_BIT = 13;
    localparam int FPEC_ERASE_BIT = 6;
    localparam int FPEC_OP_MSB = 3;
    localparam logic [15:0] FPEC_CTRL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // unlock keys and operation codes
    // ------------------------------------------------------------
    localparam logic [7:0] FPEC_KEY_FIRST = 8'h55;
    localparam logic [7:0] FPEC_KEY_SECOND = 8'hAA;
    localparam logic [3:0] FPEC_OP_ROW = 4'h1;
    localparam logic [3:0] FPEC_OP_PAGE = 4'h2;
    localparam logic [3:0] FPEC_OP_WORD = 4'h3;
    localparam logic [3:0] FPEC_OP_BULK = 4'hF;

    // ------------------------------------------------------------
    // geometry: 64-instruction rows, 8-row erase blocks
    // ------------------------------------------------------------
    localparam int FPEC_ROW_WORDS = 64;
    localparam logic [23:0] FPEC_ROW_MASK = 24'hFFFF80;
    localparam logic [23:0] FPEC_BLOCK_MASK = 24'hFFFC00;
    localparam logic [23:0] FPEC_WORD_MASK = 24'hFFFFFE;

    // ------------------------------------------------------------
    // operation timing
    // ------------------------------------------------------------
    localparam int FPEC_CLK_MHZ = 20;
    localparam int FPEC_WORD_PROG_US = 50;
    localparam int FPEC_ROW_PROG_US = 2000;
    localparam int FPEC_PAGE_ERASE_US = 20000;
    localparam int FPEC_BULK_ERASE_US = 40000;
    localparam int FPEC_WORD_PROG_CYC = FPEC_WORD_PROG_US * FPEC_CLK_MHZ;
    localparam int FPEC_ROW_PROG_CYC = FPEC_ROW_PROG_US * FPEC_CLK_MHZ;
    localparam int FPEC_PAGE_ERASE_CYC = FPEC_PAGE_ERASE_US * FPEC_CLK_MHZ;
    localparam int FPEC_BULK_ERASE_CYC = FPEC_BULK_ERASE_US * FPEC_CLK_MHZ;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FPEC_CMD_ROW,
        FPEC_CMD_WORD,
        FPEC_CMD_PAGE,
        FPEC_CMD_BULK
    } fpec_cmd_e;

    typedef enum logic [1:0] {
        FPEC_KEY_IDLE,
        FPEC_KEY_HALF,
        FPEC_KEY_ARMED
    } fpec_key_e;

endpackage

// file: src/fpec_latches.sv
/*
 * Holding latches for one flash row: 64 entries of 24 bits, written
 * as a low word and a high byte, read back by the flash macro.
 * Assumes writes come from the register slave on the same clock.
 */
module fpec_latches
    import fpec_pkg::*;
(
    // clock
    input wire logic hclk,
    // write side
    input wire logic we_lo,
    input wire logic we_hi,
    input wire logic [5:0] wr_idx,
    input wire logic [15:0] wr_data,
    // read side
    input wire logic [5:0] rd_idx,
    output logic [23:0] rd_data
);

    // contents are undefined after reset, as in the real latches
    logic [23:0] mem [FPEC_ROW_WORDS];

    always_ff @(posedge hclk) begin
        if (we_lo) begin
            mem[wr_idx][15:0] <= wr_data;
        end
        if (we_hi) begin
            mem[wr_idx][23:16] <= wr_data[7:0];
        end
    end

    always_ff @(posedge hclk) begin
        rd_data <= mem[rd_idx];
    end

endmodule // fpec_latches

// file: src/fpec_timer.sv
/*
 * Self-timed operation counter: loaded at launch, counts down once
 * per clock, pulses done on its last busy cycle.
 * Assumes start and abort come from the same clock domain.
 */
module fpec_timer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic start,
    input wire logic [31:0] load,
    input wire logic abort,
    // status
    output logic busy,
    output logic done
);

    logic [31:0] cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 32'h00000000;
        end else if (abort) begin
            cnt <= 32'h00000000;
        end else if (start) begin
            cnt <= load;
        end else if (cnt != 32'h00000000) begin
            cnt <= cnt - 32'h00000001;
        end
    end

    assign busy = (cnt != 32'h00000000);
    assign done = (cnt == 32'h00000001) && !abort;

endmodule // fpec_timer

// file: src/fpec_top.sv
/*
 * Flash program/erase controller: AHB-Lite register slave, unlock key
 * sequencer, operation decode, self-timed run with processor stall,
 * holding latches and command outputs to the flash macro.
 * Assumes hresetn is the power-on reset, sys_rst_n a synchronous
 * system reset on hclk, and serial_prog_mode an asynchronous pin.
 */

// Notes on behaviour
// - start accepted only after keys 55h then AAh
// - processor stalled while an operation runs
// - start bit set-only, hardware clears at end
// - enable bit clear inhibits program and erase
// - improper start or termination sets error flag
// - erase-select picks erase or program meaning
// - 0001 row, 0011 word, 0010 page erase
// - 1111 bulk erase only in serial mode
// - other operation codes do nothing
// - control bits cleared only by power-on
// - unimplemented control bits read zero
// - block erase clears aligned eight-row block
// - row program writes all 64 latched words
// - erase target from table page and offset
// - table writes land in latches only
// - blocks and rows aligned from address zero
module fpec_top
    import fpec_pkg::*;
#(
    parameter int P_ROW_PROG_CYC = FPEC_ROW_PROG_CYC,
    parameter int P_PAGE_ERASE_CYC = FPEC_PAGE_ERASE_CYC,
    parameter int P_BULK_ERASE_CYC = FPEC_BULK_ERASE_CYC
) (
    // clock and resets
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sys_rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // mode pin and processor stall
    input wire logic serial_prog_mode,
    output logic cpu_stall,
    // flash macro
    output logic fl_cmd_valid,
    output fpec_cmd_e fl_cmd,
    output logic [23:0] fl_addr,
    output logic fl_busy,
    input wire logic [5:0] fl_latch_idx,
    output logic [23:0] fl_latch_data
);

    // ------------------------------------------------------------
    // bus data phase
    // ------------------------------------------------------------
    logic dp_valid, dp_write;
    logic [7:0] dp_addr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    logic wr, wr_ctrl, wr_key, wr_lo, wr_hi;
    assign wr = dp_valid && dp_write;
    assign wr_ctrl = wr && (dp_addr == FPEC_OFF_CTRL);
    assign wr_key = wr && (dp_addr == FPEC_OFF_KEY);
    assign wr_lo = wr && (dp_addr == FPEC_OFF_WLO);
    assign wr_hi = wr && (dp_addr == FPEC_OFF_WHI);

    // ------------------------------------------------------------
    // serial mode pin synchroniser
    // ------------------------------------------------------------
    logic ser_s1, ser_s2, ser_s3, ser_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_s1 <= 1'b0;
            ser_s2 <= 1'b0;
            ser_s3 <= 1'b0;
            ser_mode <= 1'b0;
        end else begin
            ser_s1 <= serial_prog_mode;
            ser_s2 <= ser_s1;
            ser_s3 <= ser_s2;
            if (ser_s2 == ser_s3) begin
                ser_mode <= ser_s3;
            end
        end
    end

    // ------------------------------------------------------------
    // unlock key sequencer
    // ------------------------------------------------------------
    fpec_key_e key_st;
    // any other register write between the keys drops the unlock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_st <= FPEC_KEY_IDLE;
        end else if (!sys_rst_n) begin
            key_st <= FPEC_KEY_IDLE;
        end else if (wr_key) begin
            case (key_st)
                FPEC_KEY_IDLE, FPEC_KEY_ARMED:
                    key_st <= (hwdata[7:0] == FPEC_KEY_FIRST) ? FPEC_KEY_HALF
                                                              : FPEC_KEY_IDLE;
                FPEC_KEY_HALF:
                    key_st <= (hwdata[7:0] == FPEC_KEY_SECOND) ? FPEC_KEY_ARMED
                                                               : FPEC_KEY_IDLE;
                default: key_st <= FPEC_KEY_IDLE;
            endcase
        end else if (wr) begin
            key_st <= FPEC_KEY_IDLE;
        end
    end

    // ------------------------------------------------------------
    // control register and operation decode
    // ------------------------------------------------------------
    logic start, en, err, erase;
    logic [3:0] op;
    logic [7:0] tbl_page;
    logic [15:0] tbl_offset;
    logic op_valid;
    fpec_cmd_e op_cmd;
    logic attempt, launch, bad_start, abort, busy, done;

    always_comb begin
        op_valid = 1'b0;
        op_cmd = FPEC_CMD_ROW;
        case ({erase, op})
            {1'b0, FPEC_OP_ROW}: op_valid = 1'b1;
            {1'b0, FPEC_OP_WORD}: begin
                op_valid = 1'b1;
                op_cmd = FPEC_CMD_WORD;
            end
            {1'b1, FPEC_OP_PAGE}: begin
                op_valid = 1'b1;
                op_cmd = FPEC_CMD_PAGE;
            end
            {1'b1, FPEC_OP_BULK}: begin
                op_valid = ser_mode;
                op_cmd = FPEC_CMD_BULK;
            end
            default: op_valid = 1'b0;
        endcase
    end

    assign attempt = wr_ctrl && hwdata[FPEC_START_BIT] && !start;
    // enable and keys must already be in place before the start write
    assign launch = attempt && (key_st == FPEC_KEY_ARMED) && en && op_valid;
    assign bad_start = attempt && !((key_st == FPEC_KEY_ARMED) && en);
    // a system reset in mid-operation is an improper termination
    assign abort = !sys_rst_n && busy;

    // only power-on reset clears these; sys_rst_n does not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en <= FPEC_CTRL_RESET[FPEC_EN_BIT];
            erase <= FPEC_CTRL_RESET[FPEC_ERASE_BIT];
            op <= FPEC_CTRL_RESET[FPEC_OP_MSB:0];
        end else if (wr_ctrl) begin
            en <= hwdata[FPEC_EN_BIT];
            erase <= hwdata[FPEC_ERASE_BIT];
            op <= hwdata[FPEC_OP_MSB:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start <= FPEC_CTRL_RESET[FPEC_START_BIT];
        end else if (launch) begin
            start <= 1'b1;
        end else if (done || abort) begin
            start <= 1'b0;
        end
    end

    // hardware set wins over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err <= FPEC_CTRL_RESET[FPEC_ERR_BIT];
        end else if (bad_start || abort) begin
            err <= 1'b1;
        end else if (wr_ctrl) begin
            err <= hwdata[FPEC_ERR_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tbl_page <= 8'h00;
            tbl_offset <= 16'h0000;
        end else if (wr && (dp_addr == FPEC_OFF_PAGE)) begin
            tbl_page <= hwdata[7:0];
        end else if (wr && (dp_addr == FPEC_OFF_OFFSET)) begin
            tbl_offset <= hwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // operation launch and flash command
    // ------------------------------------------------------------
    logic [23:0] tbl_addr;
    logic [31:0] op_load;
    assign tbl_addr = {tbl_page, tbl_offset};
    always_comb begin
        case (op_cmd)
            FPEC_CMD_WORD: op_load = 32'(FPEC_WORD_PROG_CYC);
            FPEC_CMD_PAGE: op_load = 32'(P_PAGE_ERASE_CYC);
            FPEC_CMD_BULK: op_load = 32'(P_BULK_ERASE_CYC);
            default: op_load = 32'(P_ROW_PROG_CYC);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fl_cmd_valid <= 1'b0;
            fl_cmd <= FPEC_CMD_ROW;
            fl_addr <= 24'h000000;
        end else begin
            fl_cmd_valid <= launch;
            if (launch) begin
                fl_cmd <= op_cmd;
                case (op_cmd)
                    FPEC_CMD_PAGE: fl_addr <= tbl_addr & FPEC_BLOCK_MASK;
                    FPEC_CMD_ROW: fl_addr <= tbl_addr & FPEC_ROW_MASK;
                    FPEC_CMD_WORD: fl_addr <= tbl_addr & FPEC_WORD_MASK;
                    default: fl_addr <= 24'h000000;
                endcase
            end
        end
    end

    fpec_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(launch),
        .load(op_load),
        .abort(abort),
        .busy(busy),
        .done(done)
    );

    // the whole row is handed over; the macro walks fl_latch_idx
    fpec_latches u_latches (
        .hclk(hclk),
        .we_lo(wr_lo),
        .we_hi(wr_hi),
        .wr_idx(tbl_offset[6:1]),
        .wr_data(hwdata[15:0]),
        .rd_idx(fl_latch_idx),
        .rd_data(fl_latch_data)
    );

    assign fl_busy = busy;
    assign cpu_stall = busy;
    // bus stalls too, so only a write issued right behind the start write can touch registers mid-operation
    assign hreadyout = !busy;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [15:0] ctrl_rd;
    assign ctrl_rd = {start, en, err, 6'h00, erase, 2'h0, op};

    always_comb begin
        hrdata = 32'h00000000;
        if (dp_valid && !dp_write) begin
            case (dp_addr)
                FPEC_OFF_CTRL: hrdata = {16'h0000, ctrl_rd};
                FPEC_OFF_PAGE: hrdata = {24'h000000, tbl_page};
                FPEC_OFF_OFFSET: hrdata = {16'h0000, tbl_offset};
                FPEC_OFF_STAT: hrdata = {26'h0000000, fl_cmd, 1'b0,
                                         key_st == FPEC_KEY_ARMED, ser_mode, busy};
                default: hrdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    launch_after_keys_a: assert property (fl_cmd_valid |-> $past(key_st) == FPEC_KEY_ARMED)
        else $error("launch without unlock");
    stall_while_busy_a: assert property (fl_busy |-> cpu_stall && !hreadyout)
        else $error("processor not stalled during operation");
    start_held_a: assert property (fl_cmd_valid |-> start throughout fl_busy[*2])
        else $error("start bit dropped early");
    start_clears_a: assert property (done |=> !start && !fl_busy)
        else $error("start bit not cleared at end");
    disabled_no_op_a: assert property (!en |=> !fl_cmd_valid)
        else $error("operation launched while disabled");
    bad_start_err_a: assert property (bad_start |=> err && !fl_cmd_valid)
        else $error("improper start not flagged");
    bulk_serial_only_a: assert property (fl_cmd_valid && fl_cmd == FPEC_CMD_BULK
                                         |-> $past(ser_mode))
        else $error("bulk erase outside serial mode");
    bad_op_quiet_a: assert property (attempt && !op_valid |=> !fl_cmd_valid && !start)
        else $error("unimplemented operation ran");
    erase_sel_a: assert property (fl_cmd_valid && fl_cmd == FPEC_CMD_PAGE |-> $past(erase))
        else $error("erase command without erase select");
    block_align_a: assert property (fl_cmd_valid && fl_cmd == FPEC_CMD_PAGE
                                    |-> fl_addr[9:0] == 10'h000)
        else $error("erase block not aligned");
    unimpl_zero_a: assert property (ctrl_rd[12:7] == 6'h00 && ctrl_rd[5:4] == 2'h0)
        else $error("unimplemented bits not zero");
    keep_on_sysrst_a: assert property (!sys_rst_n && !wr_ctrl |=> $stable(en))
        else $error("enable changed by system reset");

    row_prog_c: cover property (fl_busy && fl_cmd == FPEC_CMD_ROW ##1 !fl_busy);
    page_erase_c: cover property (fl_cmd_valid && fl_cmd == FPEC_CMD_PAGE);
    bad_start_c: cover property (bad_start);
    abort_c: cover property (abort);

endmodule // fpec_top

// file: testbench/tb.sv
/*
 * Self-checking bench of the flash program/erase controller: AHB-Lite master
 * tasks, key sequences, every operation code, refusals, abort and resets.
 * Assumes the shortened operation lengths below; word program stays fixed.
 */
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp); end end

module tb
    import fpec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int ROW_N = 20;
    localparam int PAGE_N = 30;
    localparam int BULK_N = 40;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic sys_rst_n = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic serial_prog_mode = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [5:0] fl_latch_idx = 6'h0;
    wire logic hreadyout, hresp, cpu_stall, fl_cmd_valid, fl_busy;
    wire logic [31:0] hrdata;
    wire fpec_cmd_e fl_cmd;
    wire logic [23:0] fl_addr, fl_latch_data;
    int bad_count = 0;
    int tests_run = 0;
    int pulses = 0;
    int stall_cyc = 0;
    fpec_cmd_e last_cmd;
    logic [23:0] last_addr;
    logic [31:0] seed = 32'h4F45;

    fpec_top #(.P_ROW_PROG_CYC(ROW_N), .P_PAGE_ERASE_CYC(PAGE_N), .P_BULK_ERASE_CYC(BULK_N)) uut (
        .hclk(hclk), .hresetn(hresetn), .sys_rst_n(sys_rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .serial_prog_mode(serial_prog_mode), .cpu_stall(cpu_stall),
        .fl_cmd_valid(fl_cmd_valid), .fl_cmd(fl_cmd), .fl_addr(fl_addr), .fl_busy(fl_busy),
        .fl_latch_idx(fl_latch_idx), .fl_latch_data(fl_latch_data)
    );

    always #25 hclk = ~hclk;

    // ----------------------------------------------------------------
    // monitors and expectation helpers
    // ----------------------------------------------------------------
    always @(posedge hclk) begin
        if (cpu_stall === 1'b1) stall_cyc++;
        if (fl_cmd_valid === 1'b1) begin
            pulses++;
            last_cmd = fl_cmd;
            last_addr = fl_addr;
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // length of the operation a start would run, 0 for none
    function automatic int decode(input logic [15:0] cfg, input logic ser,
                                  output fpec_cmd_e c);
        c = FPEC_CMD_ROW;
        if (!cfg[6] && cfg[3:0] == FPEC_OP_ROW) return ROW_N;
        c = FPEC_CMD_WORD;
        if (!cfg[6] && cfg[3:0] == FPEC_OP_WORD) return FPEC_WORD_PROG_CYC;
        c = FPEC_CMD_PAGE;
        if (cfg[6] && cfg[3:0] == FPEC_OP_PAGE) return PAGE_N;
        c = FPEC_CMD_BULK;
        if (cfg[6] && cfg[3:0] == FPEC_OP_BULK && ser) return BULK_N;
        return 0;
    endfunction

    function automatic logic [23:0] aligned(input fpec_cmd_e c, input logic [23:0] a);
        case (c)
            FPEC_CMD_ROW: return a & FPEC_ROW_MASK;
            FPEC_CMD_WORD: return a & FPEC_WORD_MASK;
            FPEC_CMD_PAGE: return a & FPEC_BLOCK_MASK;
            default: return 24'h000000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // bus tasks and one programming attempt
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        // only the watchdog ends a wait for the slave
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask

    // keym: 0 no keys, 1 proper pair, 2 pair split by another write
    task automatic scen(input logic [15:0] cfg, input int keym, input logic ser,
                        input logic abort);
        logic [31:0] rd;
        logic [23:0] a;
        logic err;
        fpec_cmd_e c;
        int len, p0, s0;
        a = 24'(rnd());
        serial_prog_mode <= ser;
        wr(FPEC_OFF_PAGE, 32'(a[23:16]));
        wr(FPEC_OFF_OFFSET, 32'(a[15:0]));
        wr(FPEC_OFF_CTRL, 32'(cfg));
        if (keym > 0) wr(FPEC_OFF_KEY, 32'(FPEC_KEY_FIRST));
        if (keym == 2) wr(FPEC_OFF_PAGE, 32'(a[23:16]));
        if (keym > 0) wr(FPEC_OFF_KEY, 32'(FPEC_KEY_SECOND));
        err = keym != 1 || !cfg[14];
        len = err ? 0 : decode(cfg, ser, c);
        p0 = pulses;
        s0 = stall_cyc;
        fork
            begin
                wr(FPEC_OFF_CTRL, 32'(cfg | 16'h8000));
                repeat (2) @(posedge hclk);
                xfer(1'b0, FPEC_OFF_CTRL, 32'h0, rd);
            end
            if (abort) begin
                wait (cpu_stall === 1'b1);
                @(posedge hclk);
                sys_rst_n <= 1'b0;
                @(posedge hclk);
                sys_rst_n <= 1'b1;
            end
        join
        `CHK(pulses - p0, (len > 0) ? 1 : 0, "launch count")
        if (abort) `CHK(stall_cyc - s0 < len, 1'b1, "abort stall")
        else `CHK(stall_cyc - s0, len, "stall length")
        if (len > 0) `CHK(last_cmd, c, "command")
        if (len > 0) `CHK(last_addr, aligned(c, a), "target")
        `CHK(rd[15:0], (cfg & 16'h404F) | ((err || abort) ? 16'h2000 : 16'h0), "ctrl")
    endtask

    task tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] rd, r;
        logic [5:0] idx[4];
        logic [23:0] dat[4];
        int p0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, FPEC_OFF_CTRL, 32'h0, rd);
        `CHK(rd[15:0], FPEC_CTRL_RESET, "ctrl reset")
        p0 = pulses;
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            idx[i] = {i[1:0], r[3:0]};
            dat[i] = r[31:8];
            wr(FPEC_OFF_OFFSET, {25'h0, idx[i], 1'b0});
            wr(FPEC_OFF_WLO, 32'(dat[i][15:0]));
            wr(FPEC_OFF_WHI, 32'(dat[i][23:16]));
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            fl_latch_idx <= idx[i];
            repeat (2) @(posedge hclk);
            `CHK(fl_latch_data, dat[i], "latch")
        end
        `CHK(pulses, p0, "latch write launched")
        // every erase-select and operation code, with the mode pin at random
        for (int k = 0; k < 32; k++) begin
            r = rnd();
            scen({3'b010, 6'h0, k[4], 2'h0, k[3:0]}, 1, r[0], 1'b0);
        end
        scen(16'h404F, 1, 1'b1, 1'b0);
        scen(16'h400F, 1, 1'b1, 1'b0);
        scen(16'h0042, 1, 1'b0, 1'b0);
        scen(16'h4042, 0, 1'b0, 1'b0);
        scen(16'h4042, 2, 1'b0, 1'b0);
        scen(16'h4042, 1, 1'b0, 1'b1);
        scen(16'h4001, 1, 1'b0, 1'b0);
        wr(FPEC_OFF_CTRL, 32'h00007FFF);
        xfer(1'b0, FPEC_OFF_CTRL, 32'h0, rd);
        `CHK(rd[15:0], 16'h604F, "unimplemented bits")
        @(posedge hclk);
        sys_rst_n <= 1'b0;
        repeat (2) @(posedge hclk);
        sys_rst_n <= 1'b1;
        xfer(1'b0, FPEC_OFF_CTRL, 32'h0, rd);
        `CHK(rd[15:0], 16'h604F, "system reset kept bits")
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, FPEC_OFF_CTRL, 32'h0, rd);
        `CHK(rd[15:0], FPEC_CTRL_RESET, "power-on reset")
        tally_and_finish();
    end

    // a hung handshake ends the run through the same verdict
    initial begin
        #(50 * 60000);
        bad_count++;
        tally_and_finish();
    end
endmodule // tb
